// *** battery_and_loop_monitor_regs.sv ***
// Battery set-point, power monitor pointer and loop sense register bank on Avalon-MM.
// What this block does
// - The high battery level is a six-bit field, 1.5 V per code, resetting to code 0x32.
// - The low battery level is a six-bit field, 1.5 V per code, resetting to code 0x10.
// - The three-bit pointer selects transistors one to six; codes 110 and 111 are undefined.
// - The power byte shows the power of the transistor that the pointer selects, and zero for codes 110 and 111.
// - The loop voltage byte carries the sign in bit 6 and the magnitude in bits 5:0.
// - The loop current byte carries the direction in bit 6 and the magnitude in bits 5:0.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
module battery_and_loop_monitor_regs
   import battery_loop_pkg::*;
(
   input  wire logic                     ref_clk,              // Device clock, 125 MHz.
   input  wire logic                     rst_n,                // Synchronous reset, active low.
   input  wire logic [ADDR_WIDTH-1:0]    avs_address,          // Byte address.
   input  wire logic                     avs_read,             // Read request.
   input  wire logic                     avs_write,            // Write request.
   input  wire logic [DATA_WIDTH-1:0]    avs_writedata,        // Write data.
   input  wire logic [3:0]               avs_byteenable,       // Byte lanes.
   output logic      [DATA_WIDTH-1:0]    avs_readdata,         // Read data, registered.
   output logic                          avs_waitrequest,      // Stall until answer.
   input  wire logic [REG_WIDTH-1:0]     transistor_power_in [TRANSISTOR_COUNT], // Per-transistor power.
   input  wire logic                     loop_voltage_sign,    // 1 when ring is above tip.
   input  wire logic [LEVEL_WIDTH-1:0]   loop_voltage_magnitude, // Loop voltage, 1.5 V steps.
   input  wire logic                     loop_current_direction, // 1 for reverse current.
   input  wire logic [LEVEL_WIDTH-1:0]   loop_current_magnitude, // Loop current, 1.25 mA steps.
   output logic      [LEVEL_WIDTH-1:0]   high_battery_level,   // High battery set-point.
   output logic      [LEVEL_WIDTH-1:0]   low_battery_level,    // Low battery set-point.
   output logic      [POINTER_WIDTH-1:0] transistor_select_pointer // Monitored transistor.
);

   typedef enum logic [1:0] {
      BUS_IDLE   = 2'b01,
      BUS_ANSWER = 2'b10
   } bus_state_type;

   bus_state_type                bus_state;
   logic [REG_WIDTH-1:0]         transistor_power_value;
   logic                         request;
   logic [7:0]                   reg_index;
   logic                         aligned;
   logic [REG_WIDTH-1:0]         next_read_byte;

   // Turns a byte address into a register index; alignment is checked apart.
   function automatic logic [7:0] index_of(input logic [ADDR_WIDTH-1:0] addr);
      index_of = 8'(addr[ADDR_WIDTH-1:2]);
   endfunction : index_of

   assign request   = avs_read | avs_write;
   assign reg_index = index_of(avs_address);
   assign aligned   = (avs_address[1:0] == WORD_OFFSET_BITS);

   // Every access takes exactly one wait cycle; this keeps read data registered.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         bus_state <= BUS_IDLE;
      end else begin
         case (bus_state)
            BUS_IDLE: begin
               if (request) begin
                  bus_state <= BUS_ANSWER;
               end
            end
            BUS_ANSWER: begin
               bus_state <= BUS_IDLE;
            end
            default: begin
               bus_state <= BUS_IDLE;
            end
         endcase
      end
   end

   assign avs_waitrequest = request & (bus_state != BUS_ANSWER);

   // Writable fields, committed on the edge where waitrequest is low; only lane 0 counts.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         high_battery_level        <= HIGH_BATTERY_RESET;
         low_battery_level         <= LOW_BATTERY_RESET;
         transistor_select_pointer <= POINTER_RESET;
      end else if (avs_write && bus_state == BUS_ANSWER && aligned && avs_byteenable[0]) begin
         // The device does not enforce the ordering of the two levels; software owns it.
         case (reg_index)
            HIGH_BATTERY_SETPOINT_IDX: begin
               high_battery_level <= avs_writedata[MAG_MSB:0];
            end
            LOW_BATTERY_SETPOINT_IDX: begin
               low_battery_level <= avs_writedata[MAG_MSB:0];
            end
            POWER_MONITOR_SELECT_IDX: begin
               transistor_select_pointer <= avs_writedata[POINTER_WIDTH-1:0];
            end
            default: begin
               // Read-only and unmapped offsets ignore writes.
            end
         endcase
      end
   end

   // Pointer mux; undefined codes read zero as a harmless choice.
   always_comb begin
      if (transistor_select_pointer <= POINTER_LAST_VALID) begin
         transistor_power_value = transistor_power_in[transistor_select_pointer];
      end else begin
         transistor_power_value = '0;
      end
   end

   // Read byte selection with reserved bits forced to zero.
   always_comb begin
      next_read_byte = '0;
      if (aligned) begin
         case (reg_index)
            HIGH_BATTERY_SETPOINT_IDX:    next_read_byte = {2'h0, high_battery_level};
            LOW_BATTERY_SETPOINT_IDX:     next_read_byte = {2'h0, low_battery_level};
            POWER_MONITOR_SELECT_IDX:     next_read_byte = {5'h00, transistor_select_pointer};
            TRANSISTOR_POWER_READING_IDX: next_read_byte = transistor_power_value;
            LOOP_VOLTAGE_READING_IDX:
               next_read_byte = {1'h0, loop_voltage_sign, loop_voltage_magnitude};
            LOOP_CURRENT_READING_IDX:
               next_read_byte = {1'h0, loop_current_direction, loop_current_magnitude};
            default:                      next_read_byte = '0;
         endcase
      end
   end

   // Read data is registered in the idle cycle and stands at the answering edge.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         avs_readdata <= UNMAPPED_READ_VALUE;
      end else if (avs_read && bus_state == BUS_IDLE) begin
         avs_readdata <= {24'h00_0000, next_read_byte};
      end
   end

   // A read of the power byte returns the mux output captured one cycle earlier.
   property p_power_read;
      @(posedge ref_clk) disable iff (!rst_n)
      (avs_read && bus_state == BUS_IDLE && aligned
       && reg_index == TRANSISTOR_POWER_READING_IDX)
      |=> (avs_readdata[7:0] == $past(transistor_power_value));
   endproperty
   a_power_read: assert property (p_power_read) else $error("power byte mismatch");

   property p_power_mux;
      @(posedge ref_clk) disable iff (!rst_n)
      (transistor_select_pointer <= POINTER_LAST_VALID)
      |-> (transistor_power_value == transistor_power_in[transistor_select_pointer]);
   endproperty
   a_power_mux: assert property (p_power_mux) else $error("pointer mux wrong");

   property p_voltage_read;
      @(posedge ref_clk) disable iff (!rst_n)
      (avs_read && bus_state == BUS_IDLE && aligned && reg_index == LOOP_VOLTAGE_READING_IDX)
      |=> (avs_readdata[7:0] == {1'b0, $past(loop_voltage_sign), $past(loop_voltage_magnitude)});
   endproperty
   a_voltage_read: assert property (p_voltage_read) else $error("voltage byte wrong");

   property p_current_read;
      @(posedge ref_clk) disable iff (!rst_n)
      (avs_read && bus_state == BUS_IDLE && aligned && reg_index == LOOP_CURRENT_READING_IDX)
      |=> (avs_readdata[7:0] ==
           {1'b0, $past(loop_current_direction), $past(loop_current_magnitude)});
   endproperty
   a_current_read: assert property (p_current_read) else $error("current byte wrong");

   property p_high_write;
      @(posedge ref_clk) disable iff (!rst_n)
      (avs_write && !avs_waitrequest && aligned && avs_byteenable[0]
       && reg_index == HIGH_BATTERY_SETPOINT_IDX)
      |=> (high_battery_level == $past(avs_writedata[5:0]));
   endproperty
   a_high_write: assert property (p_high_write) else $error("high level not written");

   property p_low_write;
      @(posedge ref_clk) disable iff (!rst_n)
      (avs_write && !avs_waitrequest && aligned && avs_byteenable[0]
       && reg_index == LOW_BATTERY_SETPOINT_IDX)
      |=> (low_battery_level == $past(avs_writedata[5:0]));
   endproperty
   a_low_write: assert property (p_low_write) else $error("low level not written");

   property p_reset_levels;
      @(posedge ref_clk)
      !rst_n |=> (high_battery_level == HIGH_BATTERY_RESET
                  && low_battery_level == LOW_BATTERY_RESET
                  && transistor_select_pointer == POINTER_RESET);
   endproperty
   a_reset_levels: assert property (p_reset_levels) else $error("reset values wrong");

   // Only the low byte carries data; the power byte uses all eight of its bits.
   property p_reserved_zero;
      @(posedge ref_clk) disable iff (!rst_n)
      (avs_read && !avs_waitrequest) |-> (avs_readdata[DATA_WIDTH-1:REG_WIDTH] == '0);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

   // Bit 7 is reserved in every byte of the bank except the power reading.
   property p_top_bit_zero;
      @(posedge ref_clk) disable iff (!rst_n)
      (avs_read && bus_state == BUS_IDLE && reg_index != TRANSISTOR_POWER_READING_IDX)
      |=> (avs_readdata[REG_WIDTH-1] == 1'b0);
   endproperty
   a_top_bit_zero: assert property (p_top_bit_zero) else $error("reserved bit 7 set");

   // The set-point bytes keep their two top bits clear on read-back.
   property p_field_reserved;
      @(posedge ref_clk) disable iff (!rst_n)
      (avs_read && bus_state == BUS_IDLE && aligned
      && (reg_index == HIGH_BATTERY_SETPOINT_IDX || reg_index == LOW_BATTERY_SETPOINT_IDX))
      |=> (avs_readdata[REG_WIDTH-1:LEVEL_WIDTH] == '0);
   endproperty
   a_field_reserved: assert property (p_field_reserved) else $error("level bits 7:6 set");

   property p_pointer_write;
      @(posedge ref_clk) disable iff (!rst_n)
      (avs_write && !avs_waitrequest && aligned && avs_byteenable[0]
       && reg_index == POWER_MONITOR_SELECT_IDX)
      |=> (transistor_select_pointer == $past(avs_writedata[POINTER_WIDTH-1:0]));
   endproperty
   a_pointer_write: assert property (p_pointer_write) else $error("pointer not written");

   // A write that misses lane 0 or the word boundary must leave every field alone.
   property p_refused_write;
      @(posedge ref_clk) disable iff (!rst_n)
      (avs_write && !avs_waitrequest && !(aligned && avs_byteenable[0]))
      |=> ($stable(high_battery_level) && $stable(low_battery_level)
           && $stable(transistor_select_pointer));
   endproperty
   a_refused_write: assert property (p_refused_write) else $error("refused write landed");

   property p_one_wait;
      @(posedge ref_clk) disable iff (!rst_n)
      ($rose(avs_read) && bus_state == BUS_IDLE) |-> avs_waitrequest ##1 !avs_waitrequest;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("answer latency wrong");

endmodule : battery_and_loop_monitor_regs

// *** battery_loop_pkg.sv ***
// Package holding register offsets, field layouts, reset values and bus constants.
package battery_loop_pkg;
   // Bus and register geometry; the top byte address is 0x13C, so nine address bits.
   localparam int          ADDR_WIDTH        = 9;
   localparam int          DATA_WIDTH        = 32;
   localparam int          REG_WIDTH         = 8;
   localparam int          LEVEL_WIDTH       = 6;
   localparam int          POINTER_WIDTH     = 3;
   localparam int          TRANSISTOR_COUNT  = 6;

   // Register indices; the byte address is four times the index.
   localparam logic [7:0]  HIGH_BATTERY_SETPOINT_IDX    = 8'h4A;
   localparam logic [7:0]  LOW_BATTERY_SETPOINT_IDX     = 8'h4B;
   localparam logic [7:0]  POWER_MONITOR_SELECT_IDX     = 8'h4C;
   localparam logic [7:0]  TRANSISTOR_POWER_READING_IDX = 8'h4D;
   localparam logic [7:0]  LOOP_VOLTAGE_READING_IDX     = 8'h4E;
   localparam logic [7:0]  LOOP_CURRENT_READING_IDX     = 8'h4F;
   localparam logic [1:0]  WORD_OFFSET_BITS             = 2'h0;

   // Reset values of the writable fields.
   localparam logic [5:0]  HIGH_BATTERY_RESET  = 6'h32;
   localparam logic [5:0]  LOW_BATTERY_RESET   = 6'h10;
   localparam logic [2:0]  POINTER_RESET       = 3'h0;
   localparam logic [2:0]  POINTER_LAST_VALID  = 3'h5;

   // Field positions inside the loop status bytes.
   localparam int          SIGN_BIT            = 6;
   localparam int          MAG_MSB             = 5;
   localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h0000_0000;
endpackage : battery_loop_pkg

// *** test_battery_and_loop_monitor_regs.sv ***
// Self-checking testbench for the battery set-point and loop sense register bank.
module test_battery_and_loop_monitor_regs
   import battery_loop_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic                     ref_clk = 1'b0;
   logic                     rst_n = 1'b0;
   logic [ADDR_WIDTH-1:0]    avs_address = '0;
   logic                     avs_read = 1'b0;
   logic                     avs_write = 1'b0;
   logic [DATA_WIDTH-1:0]    avs_writedata = '0;
   logic [3:0]               avs_byteenable = 4'h0;
   logic [DATA_WIDTH-1:0]    avs_readdata;
   logic                     avs_waitrequest;
   logic [REG_WIDTH-1:0]     power_in [TRANSISTOR_COUNT];
   logic                     v_sign = 1'b0;
   logic [LEVEL_WIDTH-1:0]   v_mag = 6'h00;
   logic                     c_dir = 1'b1;
   logic [LEVEL_WIDTH-1:0]   c_mag = 6'h3F;
   logic [LEVEL_WIDTH-1:0]   high_lvl, low_lvl;
   logic [POINTER_WIDTH-1:0] pointer;
   logic [31:0]              q;
   int                       num_errors = 0, checks_done = 0, cycles = 0;
   // Ordinary rows: register index, write data, expected read-back; writes keep high >= low.
   logic [7:0]  row_idx [6] = '{LOW_BATTERY_SETPOINT_IDX, HIGH_BATTERY_SETPOINT_IDX,
      LOW_BATTERY_SETPOINT_IDX, POWER_MONITOR_SELECT_IDX, TRANSISTOR_POWER_READING_IDX,
      LOOP_CURRENT_READING_IDX};
   logic [31:0] row_wd [6] = '{32'h0000_0000, 32'hFFFF_FF3F, 32'h0000_00FF, 32'h0000_00FD,
      32'h0000_00FF, 32'h0000_00FF};
   logic [31:0] row_rd [6] = '{32'h0000_0000, 32'h0000_003F, 32'h0000_003F, 32'h0000_0005,
      32'h0000_0065, 32'h0000_007F};

   battery_and_loop_monitor_regs battery_and_loop_monitor_regs_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .transistor_power_in(power_in), .loop_voltage_sign(v_sign),
      .loop_voltage_magnitude(v_mag), .loop_current_direction(c_dir),
      .loop_current_magnitude(c_mag), .high_battery_level(high_lvl),
      .low_battery_level(low_lvl), .transistor_select_pointer(pointer));

   // Free-running 125 MHz clock; each transistor gets a distinct power code so a wrong pick shows.
   initial begin
      for (int i = 0; i < TRANSISTOR_COUNT; i++) power_in[i] = 8'h10 + 8'(i * 17);
      forever #4 ref_clk = ~ref_clk;
   end

   // Cut a hang short; the whole run needs fewer than two hundred cycles.
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         num_errors++;
         final_report();
      end
   end

   task automatic final_report();
      $display("Checks %0d, errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : final_report

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
         num_errors++;
      end
   endtask : check

   // One bus cycle; held until waitrequest is seen low at a rising edge, then one idle cycle.
   task automatic bus(input logic wr, input logic [ADDR_WIDTH-1:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      avs_address <= a;
      avs_read <= ~wr;
      avs_write <= wr;
      avs_writedata <= d;
      avs_byteenable <= be;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask : bus

   task automatic rd(input logic [ADDR_WIDTH-1:0] a, input logic [31:0] exp, input string name);
      bus(1'b0, a, 32'h0, 4'hF);
      check(name, exp, q);
   endtask : rd

   // Byte address of a register: four times its index, cut to the width of the port.
   function automatic logic [ADDR_WIDTH-1:0] ba(input logic [7:0] idx);
      return {idx[ADDR_WIDTH-3:0], WORD_OFFSET_BITS};
   endfunction : ba

   initial begin
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      check("high port", 32'h32, {26'h0, high_lvl});
      check("low port", 32'h10, {26'h0, low_lvl});
      check("pointer port", 32'h0, {29'h0, pointer});
      rd(ba(HIGH_BATTERY_SETPOINT_IDX), 32'h32, "high reset");
      rd(ba(LOW_BATTERY_SETPOINT_IDX), 32'h10, "low reset");
      rd(ba(POWER_MONITOR_SELECT_IDX), 32'h0, "pointer reset");
      for (int r = 0; r < 6; r++) begin
         bus(1'b1, ba(row_idx[r]), row_wd[r], 4'hF);
         rd(ba(row_idx[r]), row_rd[r], "row");
      end
      check("low port", 32'h3F, {26'h0, low_lvl});
      // Every pointer code; the two undefined codes read zero by the designer's choice.
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, ba(POWER_MONITOR_SELECT_IDX), 32'(i), 4'h1);
         check("pointer port", 32'(i), {29'h0, pointer});
         rd(ba(TRANSISTOR_POWER_READING_IDX), (i < 6) ? 32'h10 + 32'(i * 17) : 32'h0,
            "power");
      end
      for (int j = 0; j < 2; j++) begin
         v_sign <= j[0];
         v_mag <= j[0] ? 6'h15 : 6'h2A;
         c_dir <= j[0];
         c_mag <= j[0] ? 6'h2A : 6'h15;
         rd(ba(LOOP_VOLTAGE_READING_IDX), j[0] ? 32'h55 : 32'h2A, "loop voltage");
         rd(ba(LOOP_CURRENT_READING_IDX), j[0] ? 32'h6A : 32'h15, "loop current");
      end
      // Refused writes: lane 0 disabled, misaligned, read-only and unmapped places.
      bus(1'b1, ba(HIGH_BATTERY_SETPOINT_IDX), 32'h20, 4'hE);
      bus(1'b1, ba(HIGH_BATTERY_SETPOINT_IDX) + 9'h001, 32'h20, 4'hF);
      bus(1'b1, ba(LOOP_VOLTAGE_READING_IDX), 32'hFF, 4'hF);
      bus(1'b1, 9'h040, 32'hFF, 4'hF);
      rd(ba(HIGH_BATTERY_SETPOINT_IDX), 32'h3F, "high kept");
      rd(ba(LOOP_VOLTAGE_READING_IDX), 32'h55, "voltage kept");
      rd(9'h040, 32'h0, "unmapped");
      rd(ba(HIGH_BATTERY_SETPOINT_IDX) + 9'h001, 32'h0, "misaligned");
      bus(1'b1, ba(HIGH_BATTERY_SETPOINT_IDX), 32'h20, 4'h1);
      check("high port", 32'h20, {26'h0, high_lvl});
      // A reset in mid-run must put every writable field back to its default.
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      check("high port after reset", 32'h32, {26'h0, high_lvl});
      check("low port after reset", 32'h10, {26'h0, low_lvl});
      check("pointer port after reset", 32'h0, {29'h0, pointer});
      check("readdata after reset", 32'h0, avs_readdata);
      check("waitrequest idle", 32'h0, {31'h0, avs_waitrequest});
      rd(ba(LOW_BATTERY_SETPOINT_IDX), 32'h10, "low after reset");
      final_report();
   end
endmodule : test_battery_and_loop_monitor_regs
